//--- src/ufc_top.v
// Configuration loader, suspend control and charger detect for the bridge
// Functional notes
// - Load descriptors after power-on and bus reset
// - Config memory rewritable over the USB link
// - Charger port while suspended asserts detect output
// - Detect output polarity chosen by aux setting
// - Stay suspended on charger port, never enumerate
// - Enumerated by host keeps detect output inactive
// - Optional FIFO pull-down during suspend, default off
// - Wake input low wakes host after 20 ms
// - Report USB 2.0 version from stored value
// - Max power from memory, default 90mA bus
// - Keep-awake input blocks suspend while unplugged
// - Supply sense detects host and bus power
`timescale 1ns/100ps
`default_nettype none
`include "ufc_defs.vh"
module ufc_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        usb_bus_reset,
  input  wire        usb_bus_suspend,
  input  wire        usb_enumerated,
  input  wire        usb_lines_shorted,
  input  wire        cfg_wr_en,
  input  wire [5:0]  cfg_wr_addr,
  input  wire [15:0] cfg_wr_data,
  input  wire        send_wakeup_n,
  input  wire        aux_pin_five_in,
  input  wire        aux_pin_six_in,
  output reg         aux_pin_five_out,
  output reg         aux_pin_five_oe_n,
  output reg         aux_pin_six_out,
  output reg         aux_pin_six_oe_n,
  output reg         cfg_loaded,
  output reg         usb_pullup_en,
  output reg         suspended,
  output reg         power_enable_n,
  output reg         fifo_pulldown_en,
  output reg         remote_wake_req,
  output reg  [15:0] desc_usb_version,
  output reg  [7:0]  desc_max_power,
  output reg         desc_self_powered
);
  localparam ST_IDLE = 3'b001;
  localparam ST_READ = 3'b010;
  localparam ST_DONE = 3'b100;

  // Full-width count cut on purpose to the counter width
  localparam [31:0]            WAKE_CYC_I = `UFC_WAKE_CYC;
  localparam [`UFC_WAKE_W-1:0] WAKE_CYC   = WAKE_CYC_I[`UFC_WAKE_W-1:0];

  reg  [2:0]  state_r;
  reg  [5:0]  rd_addr_r;
  reg  [5:0]  cap_addr_r;
  reg         cap_vld_r;
  wire [15:0] rd_data;
  reg  [15:0] opt_r;
  reg  [3:0]  fn5_r;
  reg  [3:0]  fn6_r;
  reg  [`UFC_WAKE_W-1:0] wake_cnt_r;
  reg         wake_busy_r;

  // Host writes land in the memory directly; reload applies them
  ufc_cfg_mem u_mem (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (cfg_wr_en),
    .wr_addr   (cfg_wr_addr),
    .wr_data   (cfg_wr_data),
    .rd_addr   (rd_addr_r),
    .rd_data_r (rd_data)
  );

  // Loader scan: restart on every bus reset
  always @(posedge clk) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      rd_addr_r  <= 6'h00;
      cap_addr_r <= 6'h00;
      cap_vld_r  <= 1'b0;
      cfg_loaded <= 1'b0;
    end else if (usb_bus_reset) begin
      state_r    <= ST_IDLE;
      rd_addr_r  <= 6'h00;
      cap_vld_r  <= 1'b0;
      cfg_loaded <= 1'b0;
    end else begin
      cap_addr_r <= rd_addr_r;
      case (state_r)
        ST_IDLE: begin
          rd_addr_r <= 6'h00;
          cap_vld_r <= 1'b0;
          state_r   <= ST_READ;
        end
        ST_READ: begin
          cap_vld_r <= 1'b1;
          if (rd_addr_r == `UFC_CFG_LAST) begin
            state_r <= ST_DONE;
          end else begin
            rd_addr_r <= rd_addr_r + 6'h01;
          end
        end
        ST_DONE: begin
          cap_vld_r  <= 1'b0;
          cfg_loaded <= 1'b1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Capture read data one cycle behind the address
  always @(posedge clk) begin
    if (!rst_n) begin
      desc_usb_version  <= 16'h0000;
      desc_max_power    <= 8'h00;
      desc_self_powered <= 1'b0;
      opt_r             <= 16'h0000;
      fn5_r             <= `UFC_FN_NONE;
      fn6_r             <= `UFC_FN_NONE;
    end else if (cap_vld_r) begin
      case (cap_addr_r)
        `UFC_IDX_USBVER:  desc_usb_version <= rd_data;
        `UFC_IDX_MAXPWR:  desc_max_power <= rd_data[7:0];
        `UFC_IDX_OPTIONS: begin
          opt_r             <= rd_data;
          desc_self_powered <= rd_data[`UFC_OPT_SELFPWR];
        end
        `UFC_IDX_AUX5:    fn5_r <= rd_data[3:0];
        `UFC_IDX_AUX6:    fn6_r <= rd_data[3:0];
        default:          opt_r <= opt_r;
      endcase
    end
  end

  // Charger port: lines shorted and no enumeration
  wire charger_mode = usb_lines_shorted && !usb_enumerated;
  wire chg_active   = charger_mode && suspended;

  // Per-pin function decode; index 0 is pin five, index 1 is pin six
  wire [1:0] aux_in_w = {aux_pin_six_in, aux_pin_five_in};
  wire [7:0] aux_fn_w = {fn6_r, fn5_r};
  wire [1:0] pin_sense_w;
  wire [1:0] pin_keep_w;
  wire [1:0] pin_drv_w;
  wire [1:0] pin_lvl_w;
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_aux
      wire [3:0] fn_w = aux_fn_w[p*4 +: 4];
      assign pin_sense_w[p] = (fn_w == `UFC_FN_SUPPLY_SENSE);
      assign pin_keep_w[p]  = (fn_w == `UFC_FN_KEEP_AWAKE_N)
                              && !aux_in_w[p];
      assign pin_drv_w[p]   = (fn_w == `UFC_FN_CHARGER)
                              || (fn_w == `UFC_FN_CHARGER_N);
      assign pin_lvl_w[p]   = (fn_w == `UFC_FN_CHARGER_N) ?
                              !chg_active : chg_active;
    end
  endgenerate

  // No sense pin assigned means supply is taken as present; pin five wins
  reg sense_in;
  always @* begin
    sense_in = 1'b1;
    if (pin_sense_w[0]) begin
      sense_in = aux_in_w[0];
    end else if (pin_sense_w[1]) begin
      sense_in = aux_in_w[1];
    end
  end
  wire keep_awake = |pin_keep_w;

  // Suspend decision
  reg susp_nxt;
  always @* begin
    susp_nxt = 1'b0;
    if (charger_mode) begin
      susp_nxt = 1'b1;
    end else if (!sense_in) begin
      susp_nxt = !keep_awake;
    end else if (usb_bus_suspend && !usb_enumerated) begin
      susp_nxt = 1'b1;
    end else if (usb_bus_suspend) begin
      susp_nxt = 1'b1;
    end
    if (usb_enumerated && !usb_bus_suspend) begin
      susp_nxt = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      suspended        <= 1'b1;
      power_enable_n   <= 1'b1;
      fifo_pulldown_en <= 1'b0;
      usb_pullup_en    <= 1'b0;
    end else begin
      suspended        <= susp_nxt;
      power_enable_n   <= susp_nxt;
      fifo_pulldown_en <= susp_nxt && opt_r[`UFC_OPT_PDSUSP];
      // Pull-up waits for load and host power; never on a charger port
      // Bus reset drops the pull-up in the same edge as the loaded flag
      usb_pullup_en    <= cfg_loaded && sense_in && !usb_bus_reset
                          && !charger_mode;
    end
  end

  // Aux-pin outputs; oe_n low means driven
  always @(posedge clk) begin
    if (!rst_n) begin
      aux_pin_five_out  <= 1'b0;
      aux_pin_five_oe_n <= 1'b1;
      aux_pin_six_out   <= 1'b0;
      aux_pin_six_oe_n  <= 1'b1;
    end else begin
      aux_pin_five_oe_n <= !pin_drv_w[0];
      aux_pin_six_oe_n  <= !pin_drv_w[1];
      aux_pin_five_out  <= pin_lvl_w[0];
      aux_pin_six_out   <= pin_lvl_w[1];
    end
  end

  // Remote wakeup: low wake input while suspended, pulse after 20 ms
  always @(posedge clk) begin
    if (!rst_n) begin
      wake_cnt_r      <= {`UFC_WAKE_W{1'b0}};
      wake_busy_r     <= 1'b0;
      remote_wake_req <= 1'b0;
    end else begin
      remote_wake_req <= 1'b0;
      if (!wake_busy_r) begin
        wake_cnt_r <= {`UFC_WAKE_W{1'b0}};
        if (!send_wakeup_n && suspended && opt_r[`UFC_OPT_RWAKE]
            && !charger_mode) begin
          wake_busy_r <= 1'b1;
        end
      end else if (wake_cnt_r == WAKE_CYC - 1'b1) begin
        wake_busy_r     <= 1'b0;
        remote_wake_req <= 1'b1;
      end else begin
        wake_cnt_r <= wake_cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- src/ufc_defs.vh
// Constants for the USB FIFO configuration loader and charger detect block
`ifndef UFC_DEFS_VH
`define UFC_DEFS_VH

`define UFC_CLK_HZ          25000000
`define UFC_WAKE_MS         20
`define UFC_WAKE_CYC        (`UFC_CLK_HZ / 1000 * `UFC_WAKE_MS)
`define UFC_WAKE_W          20

`define UFC_MEM_AW          6
`define UFC_MEM_WORDS       64
`define UFC_CFG_WORDS       6'h08
`define UFC_CFG_LAST        6'h07

// Configuration word indices
`define UFC_IDX_USBVER      6'h00
`define UFC_IDX_MAXPWR      6'h01
`define UFC_IDX_OPTIONS     6'h02
`define UFC_IDX_AUX5        6'h03
`define UFC_IDX_AUX6        6'h04

// Option word bits
`define UFC_OPT_PDSUSP      0
`define UFC_OPT_RWAKE       1
`define UFC_OPT_SELFPWR     2

// Factory defaults
`define UFC_DEF_USBVER      16'h0200
`define UFC_DEF_MAXPWR      16'h002D
`define UFC_DEF_OPTIONS     16'h0000
`define UFC_DEF_AUX5        16'h0001
`define UFC_DEF_AUX6        16'h0002

// Auxiliary pin functions
`define UFC_FN_NONE         4'h0
`define UFC_FN_SUPPLY_SENSE 4'h1
`define UFC_FN_KEEP_AWAKE_N 4'h2
`define UFC_FN_CHARGER      4'h3
`define UFC_FN_CHARGER_N    4'h4

`endif

//--- src/ufc_cfg_mem.v
// Nonvolatile configuration memory model with factory defaults
`timescale 1ns/100ps
`default_nettype none
`include "ufc_defs.vh"
module ufc_cfg_mem (
  input  wire                  clk,
  input  wire                  rst_n,
  input  wire                  wr_en,
  input  wire [`UFC_MEM_AW-1:0] wr_addr,
  input  wire [15:0]           wr_data,
  input  wire [`UFC_MEM_AW-1:0] rd_addr,
  output reg  [15:0]           rd_data_r
);
  reg [15:0] mem_r [0:`UFC_MEM_WORDS-1];
  // Power-up state of the default-load flag; a real array keeps its cells
  reg        init_r = 1'b0;

  // Contents survive rst_n; only the first reset after power-up writes defaults
  genvar g;
  generate
    for (g = 0; g < `UFC_MEM_WORDS; g = g + 1) begin : g_word
      always @(posedge clk) begin
        if (!init_r) begin
          case (g)
            `UFC_IDX_USBVER:  mem_r[g] <= `UFC_DEF_USBVER;
            `UFC_IDX_MAXPWR:  mem_r[g] <= `UFC_DEF_MAXPWR;
            `UFC_IDX_OPTIONS: mem_r[g] <= `UFC_DEF_OPTIONS;
            `UFC_IDX_AUX5:    mem_r[g] <= `UFC_DEF_AUX5;
            `UFC_IDX_AUX6:    mem_r[g] <= `UFC_DEF_AUX6;
            default:          mem_r[g] <= 16'h0000;
          endcase
        end else if (wr_en && wr_addr == g) begin
          mem_r[g] <= wr_data;
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_n) begin
      init_r <= 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r <= 16'h0000;
    end else begin
      rd_data_r <= mem_r[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- tb/ufc_top_props.sv
// Port checker for the configuration loader and charger detect block
`timescale 1ns/100ps
`default_nettype none
module ufc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        usb_bus_reset,
  input wire logic        usb_lines_shorted,
  input wire logic        usb_enumerated,
  input wire logic        cfg_loaded,
  input wire logic        usb_pullup_en,
  input wire logic        suspended,
  input wire logic        power_enable_n,
  input wire logic        fifo_pulldown_en,
  input wire logic        remote_wake_req,
  input wire logic [15:0] desc_usb_version
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Load is about ten edges; 20 leaves margin without hiding a stall
  sequence s_load_done;
    ##[1:20] cfg_loaded;
  endsequence
  sequence s_charger_port;
    usb_lines_shorted && !usb_enumerated;
  endsequence
  AST_RST_LOAD: assert property ($rose(rst_n) |-> s_load_done)
    else $error("load after reset late");
  AST_BUSRST_LOAD: assert property ($fell(usb_bus_reset) |-> s_load_done)
    else $error("load after bus reset late");
  AST_BUSRST_CLR: assert property (usb_bus_reset |=> !cfg_loaded)
    else $error("loaded flag kept over bus reset");
  AST_PULLUP_LOAD: assert property (usb_pullup_en |-> cfg_loaded)
    else $error("pull-up before load done");
  AST_DCP_SUSP: assert property (s_charger_port |=> suspended)
    else $error("charger port not suspended");
  AST_PD_PWR: assert property (fifo_pulldown_en |-> power_enable_n)
    else $error("pulldown while powered");
  AST_PD_SUSP: assert property (fifo_pulldown_en |-> suspended)
    else $error("pulldown while awake");
  AST_WAKE_PULSE: assert property (remote_wake_req |=> !remote_wake_req)
    else $error("wake request longer than one cycle");
  AST_DESC_HOLD: assert property (cfg_loaded && $past(cfg_loaded) |->
    $stable(desc_usb_version)) else $error("descriptor moved after load");
endmodule
bind ufc_top ufc_chk u_ufc_chk (.clk, .rst_n, .usb_bus_reset,
  .usb_lines_shorted, .usb_enumerated, .cfg_loaded, .usb_pullup_en,
  .suspended, .power_enable_n, .fifo_pulldown_en, .remote_wake_req,
  .desc_usb_version);
`default_nettype wire

//--- tb/ufc_host_model.sv
// Behavioural USB host and charger port facing the block
`timescale 1ns/100ps
`default_nettype none
module ufc_host_model (
  input  wire logic        clk,
  output var  logic        usb_bus_reset,
  output var  logic        usb_bus_suspend,
  output var  logic        usb_enumerated,
  output var  logic        usb_lines_shorted,
  output var  logic        cfg_wr_en,
  output var  logic [5:0]  cfg_wr_addr,
  output var  logic [15:0] cfg_wr_data
);
  initial begin
    {usb_bus_reset, usb_bus_suspend, usb_enumerated} = 3'h0;
    {usb_lines_shorted, cfg_wr_en, cfg_wr_addr} = 8'h00;
    cfg_wr_data = 16'h0000;
  end
  task automatic bus_reset;
    @(negedge clk) usb_bus_reset = 1'b1;
    @(negedge clk) usb_bus_reset = 1'b0;
  endtask
  // Data is inverted once the strobe drops so a stale word cannot match
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    {cfg_wr_en, cfg_wr_addr, cfg_wr_data} = {1'b1, a, d};
    @(negedge clk);
    {cfg_wr_en, cfg_wr_data} = {1'b0, ~d};
  endtask
  // Mode 0 unplugged, 1 enumerating host, 2 dedicated charge port,
  // 3 enumerated host that has put the bus in suspend
  task automatic attach(input logic [1:0] m);
    @(negedge clk);
    usb_enumerated = (m == 2'd1) || (m == 2'd3);
    usb_lines_shorted = (m == 2'd2);
    usb_bus_suspend = (m == 2'd2) || (m == 2'd3);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_usb_fifo_config_and_charger_detect.sv
// Self-checking bench for config load, suspend and charger detect
`timescale 1ns/100ps
`default_nettype none
`include "ufc_defs.vh"
module tb_usb_fifo_config_and_charger_detect;
  logic clk = 0, rst_n = 0, send_wakeup_n = 1, ext5 = 1, ext6 = 1;
  wire logic usb_bus_reset, usb_bus_suspend, usb_enumerated;
  wire logic usb_lines_shorted, cfg_wr_en, cfg_loaded, usb_pullup_en;
  wire logic aux_pin_five_out, aux_pin_five_oe_n, aux_pin_six_out;
  wire logic aux_pin_six_oe_n, suspended, power_enable_n, remote_wake_req;
  wire logic fifo_pulldown_en, desc_self_powered;
  wire logic [5:0]  cfg_wr_addr;
  wire logic [15:0] cfg_wr_data, desc_usb_version;
  wire logic [7:0]  desc_max_power;
  wire logic aux_pin_five_in = aux_pin_five_oe_n ? ext5 : aux_pin_five_out;
  wire logic aux_pin_six_in = aux_pin_six_oe_n ? ext6 : aux_pin_six_out;
  int err_total = 0, n_checks = 0, cyc = 0;
  initial forever #20 clk = ~clk;
  ufc_host_model u_ufc_host_model (.clk, .usb_bus_reset, .usb_bus_suspend,
    .usb_enumerated, .usb_lines_shorted, .cfg_wr_en, .cfg_wr_addr,
    .cfg_wr_data);
  ufc_top u_ufc_top (.clk, .rst_n, .usb_bus_reset, .usb_bus_suspend,
    .usb_enumerated, .usb_lines_shorted, .cfg_wr_en, .cfg_wr_addr,
    .cfg_wr_data, .send_wakeup_n, .aux_pin_five_in, .aux_pin_six_in,
    .aux_pin_five_out, .aux_pin_five_oe_n, .aux_pin_six_out,
    .aux_pin_six_oe_n, .cfg_loaded, .usb_pullup_en, .suspended,
    .power_enable_n, .fifo_pulldown_en, .remote_wake_req,
    .desc_usb_version, .desc_max_power, .desc_self_powered);
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, g);
    chk(nm, {15'h0, e}, {15'h0, g});
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_load;
    for (int i = 0; i < 40 && cfg_loaded !== 1'b1; i++) @(negedge clk);
    settle(3);
    chb("loaded", 1'b1, cfg_loaded);
  endtask
  task automatic t_defaults;
    wait_load();
    chb("pullup_on", 1'b1, usb_pullup_en);
    chb("aux5_input", 1'b1, aux_pin_five_oe_n);
    chk("version", 16'h0200, desc_usb_version);
    chk("max_power", 16'h002D, {8'h00, desc_max_power});
    chb("self_powered", 1'b0, desc_self_powered);
  endtask
  task automatic t_sense;
    u_ufc_host_model.attach(2'd1);
    settle(4);
    chb("susp_host", 1'b0, suspended);
    ext5 = 1'b0;
    u_ufc_host_model.attach(2'd0);
    settle(4);
    chb("susp_unplug", 1'b1, suspended);
    chb("pwr_off", 1'b1, power_enable_n);
    chb("pd_default", 1'b0, fifo_pulldown_en);
    ext6 = 1'b0;
    settle(4);
    chb("keep_awake", 1'b0, suspended);
    ext6 = 1'b1;
    ext5 = 1'b1;
  endtask
  task automatic t_rewrite;
    u_ufc_host_model.wr(`UFC_IDX_USBVER, 16'h0110);
    u_ufc_host_model.wr(`UFC_IDX_MAXPWR, 16'h00FA);
    u_ufc_host_model.wr(`UFC_IDX_OPTIONS, 16'h0007);
    u_ufc_host_model.wr(`UFC_IDX_AUX5, {12'h000, `UFC_FN_CHARGER});
    u_ufc_host_model.wr(`UFC_IDX_AUX6, {12'h000, `UFC_FN_CHARGER_N});
    chk("ver_before", 16'h0200, desc_usb_version);
    u_ufc_host_model.bus_reset();
    chb("pullup_loading", 1'b0, usb_pullup_en);
    wait_load();
    chk("ver_new", 16'h0110, desc_usb_version);
    chk("pwr_new", 16'h00FA, {8'h00, desc_max_power});
    chb("self_new", 1'b1, desc_self_powered);
  endtask
  task automatic t_charger;
    u_ufc_host_model.attach(2'd2);
    settle(4);
    chb("susp_dcp", 1'b1, suspended);
    chb("chg_high", 1'b1, aux_pin_five_out);
    chb("chg_drive", 1'b0, aux_pin_five_oe_n);
    chb("chg_low", 1'b0, aux_pin_six_out);
    chb("chg6_drive", 1'b0, aux_pin_six_oe_n);
    chb("pd_on", 1'b1, fifo_pulldown_en);
    chb("pullup_dcp", 1'b0, usb_pullup_en);
  endtask
  task automatic t_enum;
    u_ufc_host_model.attach(2'd1);
    settle(4);
    chb("susp_enum", 1'b0, suspended);
    chb("chg_off_high", 1'b0, aux_pin_five_out);
    chb("chg_off_low", 1'b1, aux_pin_six_out);
    chb("pd_off", 1'b0, fifo_pulldown_en);
  endtask
  // The full wake delay is far beyond the run; only an early pulse is caught
  task automatic t_wake;
    logic seen;
    seen = 1'b0;
    u_ufc_host_model.attach(2'd3);
    settle(3);
    chb("susp_bus", 1'b1, suspended);
    chb("pd_bus", 1'b1, fifo_pulldown_en);
    send_wakeup_n = 1'b0;
    repeat (1000) begin
      @(negedge clk);
      if (remote_wake_req !== 1'b0) seen = 1'b1;
    end
    chb("wake_early", 1'b0, seen);
    send_wakeup_n = 1'b1;
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run is about 1100 cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    settle(5);
    rst_n = 1'b1;
    t_defaults();
    t_sense();
    t_rewrite();
    t_charger();
    t_enum();
    t_wake();
    print_verdict();
  end
endmodule
`default_nettype wire
